//--- hw/ira_consts.vh
// Purpose: shared constants of the i2c alias remap block
// Assumes: register index times four gives the axi byte address
// Notes: definitions only
`ifndef IRA_CONSTS_VH
`define IRA_CONSTS_VH

// ----------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------
`define IRA_TGT_BASE_IDX 10'h039
`define IRA_TGT6_IDX 10'h03f
`define IRA_TGT7_IDX 10'h040
`define IRA_ALIAS_BASE_IDX 10'h041
`define IRA_ALIAS0_IDX 10'h041
`define IRA_ALIAS1_IDX 10'h042
`define IRA_ALIAS2_IDX 10'h043
`define IRA_STATUS_IDX 10'h049

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define IRA_ADDR_MSB 7
`define IRA_ADDR_LSB 1
`define IRA_AUTO_ACK_BIT 0
`define IRA_ADDR_RESET 7'h00
`define IRA_AUTO_RESET 1'h0
`define IRA_ALIAS_OFF 7'h00

// ----------------------------------------
// axi responses and decode kinds
// ----------------------------------------
`define IRA_RESP_OKAY 2'h0
`define IRA_RESP_SLVERR 2'h2
`define IRA_KIND_NONE 2'h0
`define IRA_KIND_TGT 2'h1
`define IRA_KIND_ALIAS 2'h2
`define IRA_KIND_STATUS 2'h3

`endif

//--- hw/ira_alias_match.v
// Purpose: compare an i2c address against every alias entry
// Assumes: entries packed 7 bits each, entry 0 in the low bits
// Notes: lowest matching index wins when aliases collide
`timescale 1ns/1ps
`default_nettype none
`include "ira_consts.vh"

module ira_alias_match #(
  parameter N = 8,
  parameter IDX_W = 3
) (
  input wire [7*N-1:0] alias_vec,
  input wire [7*N-1:0] tgt_vec,
  input wire [N-1:0] auto_vec,
  input wire [6:0] addr,
  output reg hit,
  output reg [IDX_W-1:0] hit_idx,
  output reg [6:0] hit_tgt,
  output reg hit_auto
);

  integer i;

  // ----------------------------------------
  // priority search, scanned high to low
  // ----------------------------------------
  always @*
  begin
    hit = 1'b0;
    hit_idx = {IDX_W{1'b0}};
    hit_tgt = 7'h00;
    hit_auto = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      // a zero alias never matches, so that entry is off
      if (alias_vec[7*i +: 7] != `IRA_ALIAS_OFF && alias_vec[7*i +: 7] == addr)
      begin
        hit = 1'b1;
        hit_idx = i[IDX_W-1:0];
        hit_tgt = tgt_vec[7*i +: 7];
        hit_auto = auto_vec[i];
      end
    end
  end

endmodule
`default_nettype wire

//--- hw/ira_remap_top.v
// Purpose: i2c alias decoder and remapper with axi4-lite registers
// Assumes: local i2c target logic presents one address phase at a time
// Notes: one request in flight; remote answer returns on rem_valid
//
// Overview of operation
// - each entry holds a 7-bit physical target address in bits 7:1, bit 0 zero
// - a matched alias address is replaced by the physical address before forwarding
// - each entry holds a 7-bit alias in bits 7:1 compared with incoming addresses
// - an alias of zero disables its entry entirely
// - alias entry n is paired with physical address entry n
// - auto-acknowledge bit set acks every write regardless of lock or remote ack
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ira_consts.vh"

module ira_remap_top #(
  parameter N = 8,
  parameter IDX_W = 3,
  parameter AW = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire req_valid,
  output wire req_ready,
  input wire [6:0] req_addr,
  input wire req_rnw,
  output wire ans_valid,
  output reg ans_ack,
  output reg ans_miss,
  output wire fwd_valid,
  input wire fwd_ready,
  output reg [6:0] fwd_addr,
  output reg fwd_rnw,
  input wire rem_valid,
  input wire rem_ack,
  input wire link_locked
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 4'h1;
  localparam ST_FWD = 4'h2;
  localparam ST_WAIT = 4'h4;
  localparam ST_ANS = 4'h8;

  reg [3:0] state_reg;
  reg auto_cur_reg;
  reg last_hit_reg;
  reg last_ack_reg;
  reg [IDX_W-1:0] last_idx_reg;
  reg [7*N-1:0] tgt_vec_reg;
  reg [7*N-1:0] alias_vec_reg;
  reg [N-1:0] auto_vec_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [AW-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire m_hit;
  wire [IDX_W-1:0] m_idx;
  wire [6:0] m_tgt;
  wire m_auto;

  // ----------------------------------------
  // address decode helpers
  // ----------------------------------------
  function [1:0] reg_kind;
    input [AW-1:0] a;
    reg [9:0] idx;
    begin
      idx = a[11:2];
      reg_kind = `IRA_KIND_NONE;
      if (a[1:0] == 2'h0)
      begin
        if (idx >= `IRA_TGT_BASE_IDX && idx < `IRA_TGT_BASE_IDX + N)
          reg_kind = `IRA_KIND_TGT;
        else if (idx >= `IRA_ALIAS_BASE_IDX && idx < `IRA_ALIAS_BASE_IDX + N)
          reg_kind = `IRA_KIND_ALIAS;
        else if (idx == `IRA_STATUS_IDX)
          reg_kind = `IRA_KIND_STATUS;
      end
    end
  endfunction

  function [IDX_W-1:0] reg_entry;
    input [AW-1:0] a;
    reg [9:0] off;
    begin
      if (reg_kind(a) == `IRA_KIND_TGT)
        off = a[11:2] - `IRA_TGT_BASE_IDX;
      else
        off = a[11:2] - `IRA_ALIAS_BASE_IDX;
      reg_entry = off[IDX_W-1:0];
    end
  endfunction

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [1:0] wr_kind = reg_kind(aw_addr_reg);
  wire [IDX_W-1:0] wr_ent = reg_entry(aw_addr_reg);
  // only byte lane 0 carries register bits
  wire wr_lane0 = wr_fire && w_strb_reg[0];

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

  // address and data may arrive in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= {AW{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IRA_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status is read only, so a write there is refused too
        s_axi_bresp <= (wr_kind == `IRA_KIND_TGT || wr_kind == `IRA_KIND_ALIAS) ?
                       `IRA_RESP_OKAY : `IRA_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // entry registers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_entry
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          tgt_vec_reg[7*g +: 7] <= `IRA_ADDR_RESET;
          alias_vec_reg[7*g +: 7] <= `IRA_ADDR_RESET;
          auto_vec_reg[g] <= `IRA_AUTO_RESET;
        end
        else if (wr_lane0 && wr_ent == g)
        begin
          if (wr_kind == `IRA_KIND_TGT)
            tgt_vec_reg[7*g +: 7] <= w_data_reg[`IRA_ADDR_MSB:`IRA_ADDR_LSB];
          if (wr_kind == `IRA_KIND_ALIAS)
          begin
            alias_vec_reg[7*g +: 7] <= w_data_reg[`IRA_ADDR_MSB:`IRA_ADDR_LSB];
            auto_vec_reg[g] <= w_data_reg[`IRA_AUTO_ACK_BIT];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  wire [1:0] rd_kind = reg_kind(s_axi_araddr);
  wire [IDX_W-1:0] rd_ent = reg_entry(s_axi_araddr);

  assign s_axi_arready = !s_axi_rvalid;

  // read data registered, answer one cycle after the address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `IRA_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `IRA_RESP_OKAY;
      case (rd_kind)
        `IRA_KIND_TGT:
          s_axi_rdata <= {24'h000000, tgt_vec_reg[7*rd_ent +: 7], 1'b0};
        `IRA_KIND_ALIAS:
          s_axi_rdata <= {24'h000000, alias_vec_reg[7*rd_ent +: 7], auto_vec_reg[rd_ent]};
        `IRA_KIND_STATUS:
          s_axi_rdata <= {26'h0000000, last_ack_reg, last_hit_reg, last_idx_reg,
                          state_reg != ST_IDLE};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `IRA_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // alias lookup
  // ----------------------------------------
  ira_alias_match #(
    .N(N),
    .IDX_W(IDX_W)
  ) u_match (
    .alias_vec(alias_vec_reg),
    .tgt_vec(tgt_vec_reg),
    .auto_vec(auto_vec_reg),
    .addr(req_addr),
    .hit(m_hit),
    .hit_idx(m_idx),
    .hit_tgt(m_tgt),
    .hit_auto(m_auto)
  );

  // ----------------------------------------
  // request sequencer
  // ----------------------------------------
  assign req_ready = state_reg == ST_IDLE;
  assign fwd_valid = state_reg == ST_FWD;
  assign ans_valid = state_reg == ST_ANS;

  // auto-acked writes still go out when the link is up, but
  // the answer waits only for fwd_ready, never for rem_valid
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      auto_cur_reg <= 1'b0;
      fwd_addr <= 7'h00;
      fwd_rnw <= 1'b0;
      ans_ack <= 1'b0;
      ans_miss <= 1'b0;
      last_hit_reg <= 1'b0;
      last_ack_reg <= 1'b0;
      last_idx_reg <= {IDX_W{1'b0}};
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (req_valid)
          begin
            last_hit_reg <= m_hit;
            last_idx_reg <= m_idx;
            fwd_addr <= m_tgt;
            fwd_rnw <= req_rnw;
            auto_cur_reg <= m_auto && !req_rnw;
            if (!m_hit)
            begin
              ans_ack <= 1'b0;
              ans_miss <= 1'b1;
              state_reg <= ST_ANS;
            end
            else if (!link_locked)
            begin
              ans_ack <= m_auto && !req_rnw;
              ans_miss <= 1'b0;
              state_reg <= ST_ANS;
            end
            else
              state_reg <= ST_FWD;
          end
        ST_FWD:
          if (fwd_ready)
          begin
            if (auto_cur_reg)
            begin
              ans_ack <= 1'b1;
              ans_miss <= 1'b0;
              state_reg <= ST_ANS;
            end
            else
              state_reg <= ST_WAIT;
          end
        ST_WAIT:
          if (rem_valid)
          begin
            ans_ack <= rem_ack;
            ans_miss <= 1'b0;
            state_reg <= ST_ANS;
          end
        ST_ANS:
        begin
          last_ack_reg <= ans_ack;
          state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- testbench/ira_remap_sva.sv
// Purpose: protocol checks for the alias remap top
// Assumes: sees ports of ira_remap_top only
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module ira_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_rnw,
  input wire logic ans_valid,
  input wire logic ans_ack,
  input wire logic ans_miss,
  input wire logic fwd_valid,
  input wire logic fwd_ready,
  input wire logic [6:0] fwd_addr,
  input wire logic fwd_rnw,
  input wire logic rem_valid,
  input wire logic rem_ack,
  input wire logic link_locked
);
  default clocking dck @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------
  // assertions
  // --------
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_miss_nack: assert property (ans_valid && ans_miss |-> !ans_ack)
    else $error("miss acked");
  a_req_reply: assert property (req_valid && req_ready |=> ans_valid || fwd_valid)
    else $error("request not answered");
  a_fwd_kind: assert property ($rose(fwd_valid) |-> fwd_rnw == $past(req_rnw))
    else $error("forward direction wrong");
  a_fwd_hold: assert property (fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_addr))
    else $error("forward dropped");
  a_link_down: assert property (req_valid && req_ready && !link_locked |=> ans_valid)
    else $error("no local answer");
  a_rem_relay: assert property (rem_valid && !req_ready && !fwd_valid && !ans_valid
    |=> ans_valid && ans_ack == $past(rem_ack) && !ans_miss)
    else $error("remote ack not relayed");
  a_ans_pulse: assert property (ans_valid |=> !ans_valid && req_ready)
    else $error("answer too long");
  // main scenarios seen
  c_fwd: cover property (fwd_valid && fwd_ready);
  c_miss: cover property (ans_valid && ans_miss);
  c_relay: cover property (rem_valid && !req_ready && !fwd_valid);
endmodule
bind ira_remap_top ira_chk u_chk (.aclk, .aresetn, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .req_valid, .req_ready, .req_rnw, .ans_valid, .ans_ack, .ans_miss,
  .fwd_valid, .fwd_ready, .fwd_addr, .fwd_rnw, .rem_valid, .rem_ack, .link_locked);
`default_nettype wire

//--- testbench/ira_rem_model.sv
// Purpose: remote deserializer side of the control channel
// Assumes: one forward in flight
// Notes: ack line shows the inverse outside its pulse
`timescale 1ns/1ps
`default_nettype none
module ira_rem_model (
  input wire logic aclk,
  input wire logic fwd_valid,
  input wire logic [6:0] fwd_addr,
  input wire logic fwd_rnw,
  input wire logic [3:0] lag,
  input wire logic ack_cfg,
  output logic fwd_ready,
  output logic rem_valid,
  output logic rem_ack,
  output logic [6:0] got_addr,
  output logic got_rnw,
  output int n_fwd
);
  // take a forward after lag cycles, answer after lag more
  initial
  begin
    fwd_ready = 1'b0;
    rem_valid = 1'b0;
    rem_ack = 1'b0;
    n_fwd = 0;
    forever
    begin
      @(posedge aclk);
      if (fwd_valid)
      begin
        repeat (lag) @(posedge aclk);
        fwd_ready <= 1'b1;
        @(posedge aclk);
        got_addr = fwd_addr;
        got_rnw = fwd_rnw;
        n_fwd++;
        fwd_ready <= 1'b0;
        repeat (lag) @(posedge aclk);
        rem_ack <= ack_cfg;
        rem_valid <= 1'b1;
        @(posedge aclk);
        rem_valid <= 1'b0;
        rem_ack <= ~ack_cfg;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: self-checking bench for the alias remap top
// Assumes: byte address is four times the register index
// Notes: remote side is ira_rem_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, req_valid, req_ready, req_rnw, ans_valid, ans_ack, ans_miss;
  logic fwd_valid, fwd_ready, fwd_rnw, rem_valid, rem_ack, link_locked, ack_cfg, got_rnw;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] req_addr, fwd_addr, got_addr;
  logic [3:0] lag, s_axi_wstrb;
  int bad_count = 0, tests_run = 0, n_fwd, n0, k = 0;
  // 50 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ira_remap_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready,
    .req_addr, .req_rnw, .ans_valid, .ans_ack, .ans_miss, .fwd_valid, .fwd_ready,
    .fwd_addr, .fwd_rnw, .rem_valid, .rem_ack, .link_locked);
  ira_rem_model u_rem (.aclk, .fwd_valid, .fwd_addr, .fwd_rnw, .lag, .ack_cfg,
    .fwd_ready, .rem_valid, .rem_ack, .got_addr, .got_rnw, .n_fwd);
  // --------
  // bus tasks
  // --------
  task automatic wr(input [9:0] i, input [7:0] d, input [1:0] e);
    begin
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, e)
      // one idle edge, so a following call never re-drives bready in this step
      @(posedge aclk);
    end
  endtask
  task automatic rd(input [9:0] i, input [7:0] d, input [1:0] e);
    begin
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, {24'h0, d})
      `CHK(s_axi_rresp, e)
      // one idle edge, so a following call never re-drives rready in this step
      @(posedge aclk);
    end
  endtask
  // one local address phase, answer checked
  task automatic rq(input [6:0] a, input w, input ak, input m);
    begin
      req_addr <= a;
      req_rnw <= w;
      req_valid <= 1'b1;
      do @(posedge aclk); while (!req_ready);
      req_valid <= 1'b0;
      do @(posedge aclk); while (!ans_valid);
      `CHK(ans_ack, ak)
      `CHK(ans_miss, m)
    end
  endtask
  task automatic te;
    begin
      k++;
      $display("test %0d done", k);
    end
  endtask
  task automatic test_done;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // --------
  // tests
  // --------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, req_valid, req_rnw, link_locked, lag} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_addr} = 0;
    ack_cfg = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 'h3f; i <= 'h43; i++)
      rd(i[9:0], 8'h00, 2'h0);
    te;
    wr(10'h03f, 8'hff, 2'h0);
    rd(10'h03f, 8'hfe, 2'h0);
    wr(10'h040, 8'h55, 2'h0);
    rd(10'h040, 8'h54, 2'h0);
    wr(10'h042, 8'h0b, 2'h0);
    rd(10'h042, 8'h0b, 2'h0);
    wr(10'h3ff, 8'h11, 2'h2);
    rd(10'h3ff, 8'h00, 2'h2);
    wr(10'h049, 8'h00, 2'h2);
    // lane 0 not strobed, the alias entry must keep its reset value
    s_axi_wstrb <= 4'he;
    wr(10'h043, 8'h0b, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(10'h043, 8'h00, 2'h0);
    te;
    link_locked <= 1'b1;
    rq(7'h00, 1'b0, 1'b0, 1'b1);
    rq(7'h20, 1'b1, 1'b0, 1'b1);
    te;
    // entries 6 and 7 forward to their own physical address
    wr(10'h047, 8'h40, 2'h0);
    wr(10'h048, 8'h42, 2'h0);
    lag <= 4'h2;
    rq(7'h20, 1'b0, 1'b1, 1'b0);
    `CHK(got_addr, 7'h7f)
    `CHK(got_rnw, 1'b0)
    ack_cfg <= 1'b0;
    lag <= 4'h0;
    rq(7'h21, 1'b1, 1'b0, 1'b0);
    `CHK(got_addr, 7'h2a)
    `CHK(got_rnw, 1'b1)
    te;
    // debug auto ack on entry 1, alias 0x05
    link_locked <= 1'b0;
    n0 = n_fwd;
    rq(7'h05, 1'b0, 1'b1, 1'b0);
    // status: last ack 1, last hit 1, entry 1, idle
    rd(10'h049, 8'h32, 2'h0);
    rq(7'h05, 1'b1, 1'b0, 1'b0);
    `CHK(n_fwd, n0)
    link_locked <= 1'b1;
    rq(7'h05, 1'b0, 1'b1, 1'b0);
    wr(10'h042, 8'h0a, 2'h0);
    link_locked <= 1'b0;
    rq(7'h05, 1'b0, 1'b0, 1'b0);
    te;
    wr(10'h048, 8'h00, 2'h0);
    rq(7'h21, 1'b0, 1'b0, 1'b1);
    te;
    test_done;
  end
  // hang guard
  initial
  begin
    repeat (4000) @(posedge aclk);
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
